// [rtl/hpc_pkg.sv]
// Shared constants, field layouts and carrier types for the hub port
// configuration block.
// Assumes a 100 MHz system clock and an AHB-Lite register bus.
// Operation
// [RULE_01] Byte one bit 3 steers EOF1 EOP
// [RULE_02] FS only: EOP at EOF1 unless suppressed
// [RULE_03] Sense field: ganged, per-port or none
// [RULE_04] Configurer: no sensing only when bus-powered
// [RULE_05] Byte one bit 0: ganged/individual power
// [RULE_06] Timer field 5:4 picks 50-400 ns delay
// [RULE_07] Byte two bit 3 reports compound device
// [RULE_08] Configurer marks compound ports non-removable too
// [RULE_09] Strap mode: any fixed port means compound
// [RULE_10] Standard mode: contiguous renumbering past disabled ports
// [RULE_11] Standard mode: enables from straps or disable registers
// [RULE_12] Remap mode: numbers from two remap registers
// [RULE_13] Fixed-device byte: one flag per port
// [RULE_14] Fixed bits 3:1 are ports; rest reserved
// [RULE_15] Default config: strap pins pick fixed ports
// [RULE_16] Firmware sets fixed bit 1 for reader
// [RULE_17] Reserved bits read zero, writes ignored
package hpc_pkg;

   // Clock rate used to turn times into cycles
   localparam int CLK_MHZ = 100;

   // Register indices; byte address is four times the index
   localparam logic [15:0] IDX_CFG_ONE = 16'h00E4;
   localparam logic [15:0] IDX_CFG_TWO = 16'h00E5;
   localparam logic [15:0] IDX_CFG_THREE = 16'h00E6;
   localparam logic [15:0] IDX_FIXED_PORTS = 16'h00E7;
   localparam logic [15:0] IDX_OFF_SELF = 16'h300A;
   localparam logic [15:0] IDX_OFF_BUS = 16'h300B;
   localparam logic [15:0] IDX_REMAP_LOW = 16'h30FB;
   localparam logic [15:0] IDX_REMAP_THIRD = 16'h30FC;
   localparam logic [15:0] IDX_STATUS = 16'h3100;

   // Writable bit masks; everything else is reserved
   localparam logic [7:0] MASK_CFG_ONE = 8'hAF;
   localparam logic [7:0] MASK_CFG_TWO = 8'h38;
   localparam logic [7:0] MASK_CFG_THREE = 8'h08;
   localparam logic [7:0] MASK_PORTS = 8'h0E;
   localparam logic [7:0] MASK_REMAP_LOW = 8'h33;
   localparam logic [7:0] MASK_REMAP_THIRD = 8'h03;

   // Reset values of the registers
   localparam logic [7:0] RST_CFG_ONE = 8'h00;
   localparam logic [7:0] RST_CFG_TWO = 8'h00;
   localparam logic [7:0] RST_CFG_THREE = 8'h00;
   localparam logic [7:0] RST_FIXED_PORTS = 8'h00;
   localparam logic [7:0] RST_PORT_OFF = 8'h00;
   localparam logic [7:0] RST_REMAP = 8'h00;

   // Field positions, byte one
   localparam int POS_SELF_POWERED = 7;
   localparam int POS_HS_OFF = 5;
   localparam int POS_EOP_SUPPRESS = 3;
   localparam int POS_SENSE_LO = 1;
   localparam int POS_POWER_MODE = 0;
   // Byte two
   localparam int POS_OC_DELAY_LO = 4;
   localparam int POS_COMPOUND = 3;
   // Byte three
   localparam int POS_REMAP_EN = 3;
   // Remap nibbles: port 1 in 1:0, port 2 in 5:4, port 3 in 1:0 of third
   localparam int POS_REMAP_P1 = 0;
   localparam int POS_REMAP_P2 = 4;

   // Sense modes (upper bit set means no sensing)
   localparam logic [1:0] SENSE_GANGED = 2'h0;
   localparam logic [1:0] SENSE_PER_PORT = 2'h1;

   // Over-current delay times in ns
   localparam int OC_DELAY_NS_0 = 50;
   localparam int OC_DELAY_NS_1 = 100;
   localparam int OC_DELAY_NS_2 = 200;
   localparam int OC_DELAY_NS_3 = 400;

   // Least time in ns to cycles, rounded up, at least one
   function automatic int ns_to_cycles(input int ns);
      int c;
      c = (ns * CLK_MHZ + 999) / 1000;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int OC_CYC_0 = ns_to_cycles(OC_DELAY_NS_0);
   localparam int OC_CYC_1 = ns_to_cycles(OC_DELAY_NS_1);
   localparam int OC_CYC_2 = ns_to_cycles(OC_DELAY_NS_2);
   localparam int OC_CYC_3 = ns_to_cycles(OC_DELAY_NS_3);
   localparam int OC_CW = 6;

   // AHB transfer type codes
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   // Decoded hub behaviour handed to port logic
   typedef struct packed {
      logic eop_at_eof1_enable;
      logic [1:0] sense_mode;
      logic power_individual;
      logic [1:0] oc_delay_code;
      logic compound;
      logic remap_mode;
      logic [3:1] fixed_ports;
      logic [3:1] port_enabled;
      logic [1:0] reported_p1;
      logic [1:0] reported_p2;
      logic [1:0] reported_p3;
      logic [1:0] port_count;
   } hpc_hub_cfg_t;

endpackage

// [rtl/hpc_oc_qual.sv]
// Over-current qualifier: a fault counts only after it stays for the
// selected delay. Assumes synchronous fault inputs on hclk.
`timescale 1ns/10ps
`default_nettype none
module hpc_oc_qual
   import hpc_pkg::*;
#(
   parameter int PORTS = 3
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [PORTS-1:0] oc_raw,
   input wire logic [1:0] sense_mode,
   input wire logic [OC_CW-1:0] delay_cycles,
   output logic [PORTS-1:0] oc_flag
);

   // Effective fault per port after the sense mode
   logic [PORTS-1:0] oc_eff;
   // Hold counters, one per port
   logic [OC_CW-1:0] hold_cnt [PORTS];

   // [RULE_03] Sense mode select
   always_comb begin
      for (int i = 0; i < PORTS; i++) begin
         if (sense_mode[1]) begin
            oc_eff[i] = 1'b0;
         end else if (sense_mode == SENSE_GANGED) begin
            oc_eff[i] = |oc_raw;
         end else begin
            oc_eff[i] = oc_raw[i];
         end
      end
   end

   // [RULE_06] Delay qualification counters
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < PORTS; i++) begin
            hold_cnt[i] <= '0;
         end
         oc_flag <= '0;
      end else begin
         for (int i = 0; i < PORTS; i++) begin
            if (!oc_eff[i]) begin
               hold_cnt[i] <= '0;
               oc_flag[i] <= 1'b0;
            end else if (hold_cnt[i] + OC_CW'(1) >= delay_cycles) begin
               // Saturate once the fault has lasted long enough
               hold_cnt[i] <= delay_cycles;
               oc_flag[i] <= 1'b1;
            end else begin
               hold_cnt[i] <= hold_cnt[i] + OC_CW'(1);
            end
         end
      end
   end

endmodule
`default_nettype wire

// [rtl/hpc_hub_config.sv]
// Hub port configuration bank: AHB-Lite registers, strap handling,
// port numbering, EOF1 end-of-packet decision and over-current delay.
// Assumes all inputs synchronous to hclk; one master on the bus.
`timescale 1ns/10ps
`default_nettype none
module hpc_hub_config
   import hpc_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [15:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // Strap inputs
   input wire logic cfg_from_strap,
   input wire logic [1:0] fixed_device_strap_pins,
   input wire logic [1:0] port_off_strap_pins,
   // Link state and frame timing
   input wire logic full_speed,
   input wire logic eof1_point,
   input wire logic downstream_traffic_seen,
   // Raw over-current faults, ports 3..1
   input wire logic [2:0] oc_raw,
   // Decoded configuration and events
   output hpc_hub_cfg_t hub_cfg,
   output logic eof1_eop_send,
   output logic [2:0] oc_qualified
);

   ////////////////////////////////////////////////////////////////////
   // Storage and helpers

   // Configuration registers
   logic [7:0] hub_config_byte_one;
   logic [7:0] hub_config_byte_two;
   logic [7:0] hub_config_byte_three;
   logic [7:0] fixed_device_ports;
   logic [7:0] port_off_self_powered;
   logic [7:0] port_off_bus_powered;
   logic [7:0] port_remap_low_pair;
   logic [7:0] port_remap_third;

   // Captured address phase
   logic wr_pending;
   logic [15:0] wr_addr;

   // Decoded values, combinational
   hpc_hub_cfg_t next_hub_cfg;
   logic [3:1] port_off;
   logic [3:1] fixed_flags;
   logic [OC_CW-1:0] delay_cycles;
   logic [7:0] rd_byte;
   logic [7:0] status_byte;

   // Byte address of a register index
   function automatic logic [15:0] reg_addr(input logic [15:0] idx);
      return {idx[13:0], 2'b00};
   endfunction

   // Contiguous number of a port: enabled ports at or below it
   function automatic logic [1:0] rank(input logic [3:1] en, input int n);
      logic [1:0] r;
      r = 2'h0;
      for (int k = 1; k <= 3; k++) begin
         if (k <= n && en[k]) begin
            r = r + 2'h1;
         end
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Bus slave

   // Valid transfer seen in an address phase
   logic take;
   assign take = hsel && hready && (htrans == HTRANS_NONSEQ);

   // Answers: zero wait states and always OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // Address phase capture for writes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pending <= 1'b0;
         wr_addr <= 16'h0000;
      end else begin
         wr_pending <= take && hwrite;
         if (take && hwrite) begin
            wr_addr <= haddr;
         end
      end
   end

   // Read mux; unmapped addresses read zero
   always_comb begin
      unique case (haddr)
         reg_addr(IDX_CFG_ONE): rd_byte = hub_config_byte_one;
         reg_addr(IDX_CFG_TWO): rd_byte = hub_config_byte_two;
         reg_addr(IDX_CFG_THREE): rd_byte = hub_config_byte_three;
         reg_addr(IDX_FIXED_PORTS): rd_byte = fixed_device_ports;
         reg_addr(IDX_OFF_SELF): rd_byte = port_off_self_powered;
         reg_addr(IDX_OFF_BUS): rd_byte = port_off_bus_powered;
         reg_addr(IDX_REMAP_LOW): rd_byte = port_remap_low_pair;
         reg_addr(IDX_REMAP_THIRD): rd_byte = port_remap_third;
         reg_addr(IDX_STATUS): rd_byte = status_byte;
         default: rd_byte = 8'h00;
      endcase
   end

   // Status: live port enables, count and qualified faults
   assign status_byte = {hub_cfg.port_count, oc_qualified, hub_cfg.port_enabled};

   // Read data registered so it stands in the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (take && !hwrite) begin
         hrdata <= {24'h00_0000, rd_byte};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Register writes

   // [RULE_17] Masked writes keep reserved bits zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hub_config_byte_one <= RST_CFG_ONE;
         hub_config_byte_two <= RST_CFG_TWO;
         hub_config_byte_three <= RST_CFG_THREE;
         fixed_device_ports <= RST_FIXED_PORTS;
      end else if (wr_pending) begin
         // Configuration bytes
         if (wr_addr == reg_addr(IDX_CFG_ONE)) begin
            hub_config_byte_one <= hwdata[7:0] & MASK_CFG_ONE;
         end
         if (wr_addr == reg_addr(IDX_CFG_TWO)) begin
            hub_config_byte_two <= hwdata[7:0] & MASK_CFG_TWO;
         end
         if (wr_addr == reg_addr(IDX_CFG_THREE)) begin
            hub_config_byte_three <= hwdata[7:0] & MASK_CFG_THREE;
         end
         // [RULE_14] Only port bits 3:1 kept
         if (wr_addr == reg_addr(IDX_FIXED_PORTS)) begin
            fixed_device_ports <= hwdata[7:0] & MASK_PORTS;
         end
      end
   end

   // [RULE_11] Disable registers, reset to zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         port_off_self_powered <= RST_PORT_OFF;
         port_off_bus_powered <= RST_PORT_OFF;
      end else if (wr_pending) begin
         if (wr_addr == reg_addr(IDX_OFF_SELF)) begin
            port_off_self_powered <= hwdata[7:0] & MASK_PORTS;
         end
         if (wr_addr == reg_addr(IDX_OFF_BUS)) begin
            port_off_bus_powered <= hwdata[7:0] & MASK_PORTS;
         end
      end
   end

   // [RULE_12] Remap registers, reset to zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         port_remap_low_pair <= RST_REMAP;
         port_remap_third <= RST_REMAP;
      end else if (wr_pending) begin
         if (wr_addr == reg_addr(IDX_REMAP_LOW)) begin
            port_remap_low_pair <= hwdata[7:0] & MASK_REMAP_LOW;
         end
         if (wr_addr == reg_addr(IDX_REMAP_THIRD)) begin
            port_remap_third <= hwdata[7:0] & MASK_REMAP_THIRD;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Configuration decode

   // [RULE_15] Strap pins pick fixed ports in default mode
   always_comb begin
      if (cfg_from_strap) begin
         fixed_flags = {1'b0, fixed_device_strap_pins[1], fixed_device_strap_pins[0]};
      end else begin
         // [RULE_13] One flag per port from the byte
         fixed_flags = fixed_device_ports[3:1];
      end
   end

   // [RULE_11] Disabled ports from straps or the powered-mode register
   always_comb begin
      if (cfg_from_strap) begin
         port_off = {port_off_strap_pins[1], port_off_strap_pins[0], 1'b0};
      end else if (hub_config_byte_one[POS_SELF_POWERED]) begin
         port_off = port_off_self_powered[3:1];
      end else begin
         port_off = port_off_bus_powered[3:1];
      end
   end

   // [RULE_06] Delay code to cycle count
   always_comb begin
      unique case (hub_config_byte_two[POS_OC_DELAY_LO +: 2])
         2'h0: delay_cycles = OC_CW'(OC_CYC_0);
         2'h1: delay_cycles = OC_CW'(OC_CYC_1);
         2'h2: delay_cycles = OC_CW'(OC_CYC_2);
         2'h3: delay_cycles = OC_CW'(OC_CYC_3);
      endcase
   end

   // Decode of the whole hub view
   always_comb begin
      next_hub_cfg = '0;
      // [RULE_01] Byte one bit 3 suppresses the EOF1 packet
      next_hub_cfg.eop_at_eof1_enable = !hub_config_byte_one[POS_EOP_SUPPRESS];
      // [RULE_03] Sense mode field 2:1
      next_hub_cfg.sense_mode = hub_config_byte_one[POS_SENSE_LO +: 2];
      // [RULE_05] Ganged or individual power
      next_hub_cfg.power_individual = hub_config_byte_one[POS_POWER_MODE];
      next_hub_cfg.oc_delay_code = hub_config_byte_two[POS_OC_DELAY_LO +: 2];
      // [RULE_09] Straps: any fixed port forces compound
      if (cfg_from_strap) begin
         next_hub_cfg.compound = |fixed_flags;
      end else begin
         // [RULE_07] Compound bit reported as stored
         next_hub_cfg.compound = hub_config_byte_two[POS_COMPOUND];
      end
      next_hub_cfg.fixed_ports = fixed_flags;
      next_hub_cfg.remap_mode = hub_config_byte_three[POS_REMAP_EN];
      if (hub_config_byte_three[POS_REMAP_EN]) begin
         // [RULE_12] Numbers taken from remap registers; zero means off
         next_hub_cfg.reported_p1 = port_remap_low_pair[POS_REMAP_P1 +: 2];
         next_hub_cfg.reported_p2 = port_remap_low_pair[POS_REMAP_P2 +: 2];
         next_hub_cfg.reported_p3 = port_remap_third[POS_REMAP_P1 +: 2];
         next_hub_cfg.port_enabled = {next_hub_cfg.reported_p3 != 2'h0,
                                      next_hub_cfg.reported_p2 != 2'h0,
                                      next_hub_cfg.reported_p1 != 2'h0};
      end else begin
         // [RULE_10] Contiguous numbering past disabled ports
         next_hub_cfg.port_enabled = ~port_off;
         next_hub_cfg.reported_p1 = port_off[1] ? 2'h0 : rank(~port_off, 1);
         next_hub_cfg.reported_p2 = port_off[2] ? 2'h0 : rank(~port_off, 2);
         next_hub_cfg.reported_p3 = port_off[3] ? 2'h0 : rank(~port_off, 3);
      end
      next_hub_cfg.port_count = rank(next_hub_cfg.port_enabled, 3);
   end

   // Decoded view held in a register for the port logic
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hub_cfg <= '0;
      end else begin
         hub_cfg <= next_hub_cfg;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Frame end and over-current

   // [RULE_02] FS-only EOP at EOF1 when idle and not suppressed
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         eof1_eop_send <= 1'b0;
      end else begin
         eof1_eop_send <= full_speed && eof1_point && !downstream_traffic_seen
                          && !hub_config_byte_one[POS_EOP_SUPPRESS];
      end
   end

   // [RULE_06] Faults qualified by the selected delay
   hpc_oc_qual #(
      .PORTS(3)
   ) u_oc_qual (
      .hclk(hclk),
      .hresetn(hresetn),
      .oc_raw(oc_raw),
      .sense_mode(hub_config_byte_one[POS_SENSE_LO +: 2]),
      .delay_cycles(delay_cycles),
      .oc_flag(oc_qualified)
   );

endmodule
`default_nettype wire

// [bench/hpc_hub_config_chk.sv]
// Assertions on the hub port configuration bank, seen from its ports.
// Assumes one hclk domain and hub_cfg one cycle behind the registers.
`timescale 1ns/10ps
`default_nettype none
module hpc_hub_config_chk
   import hpc_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [31:0] hrdata,
   input wire logic cfg_from_strap,
   input wire logic full_speed,
   input wire logic eof1_point,
   input wire logic downstream_traffic_seen,
   input wire logic [2:0] oc_raw,
   input wire hpc_hub_cfg_t hub_cfg,
   input wire logic eof1_eop_send,
   input wire logic [2:0] oc_qualified
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   ////////////////////////////////////////////////////////////////////////
   // Edges that port 1 has been faulty in a row, saturating
   logic [5:0] run;
   // Edges needed for the current delay code: 5, 10, 20, 40
   logic [5:0] need;
   assign need = 6'h05 << hub_cfg.oc_delay_code;
   // Fault run counter; cleared as soon as the fault drops
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         run <= 6'h00;
      end else if (!oc_raw[0]) begin
         run <= 6'h00;
      end else if (run != 6'h3F) begin
         run <= run + 6'h01;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Quiet full-speed EOF1 with the enable steady on both sides
   sequence s_eof1_due;
      eof1_point && full_speed && !downstream_traffic_seen &&
      hub_cfg.eop_at_eof1_enable ##1 hub_cfg.eop_at_eof1_enable;
   endsequence
   // Two samples of one sense mode, so a mode change has settled
   sequence s_mode_held(logic [1:0] m);
      hub_cfg.sense_mode == m ##1 hub_cfg.sense_mode == m;
   endsequence
   a_eop_sent: assert property (s_eof1_due |-> eof1_eop_send)
      else $error("no EOP after a quiet EOF1");
   a_eop_cause: assert property (eof1_eop_send |-> $past(eof1_point) &&
      $past(full_speed) && !$past(downstream_traffic_seen))
      else $error("EOP without a quiet full-speed EOF1");
   a_rsvd_read_zero: assert property (hrdata[31:8] == 24'h000000)
      else $error("upper read data not zero");
   a_oc_none: assert property (s_mode_held(2'h2) |-> oc_qualified == 3'h0)
      else $error("fault flagged with sensing off");
   a_oc_ganged: assert property (s_mode_held(SENSE_GANGED) |->
      oc_qualified == 3'h0 || oc_qualified == 3'h7)
      else $error("ganged flags differ");
   a_oc_delay: assert property ($rose(oc_qualified[0]) &&
      hub_cfg.sense_mode == SENSE_PER_PORT |-> run == need)
      else $error("fault qualified after wrong time");
   a_oc_deadline: assert property (hub_cfg.sense_mode == SENSE_PER_PORT &&
      run == need |-> oc_qualified[0])
      else $error("fault not qualified in time");
   a_strap_compound: assert property (cfg_from_strap && $past(cfg_from_strap) &&
      hub_cfg.fixed_ports != 3'h0 |-> hub_cfg.compound)
      else $error("strapped fixed port without compound");
   a_port_count: assert property (!hub_cfg.remap_mode |->
      hub_cfg.port_count == $countones(hub_cfg.port_enabled))
      else $error("port count not number enabled");
endmodule
bind hpc_hub_config hpc_hub_config_chk u_hpc_hub_config_chk (.hclk(hclk),
   .hresetn(hresetn), .hrdata(hrdata), .cfg_from_strap(cfg_from_strap),
   .full_speed(full_speed), .eof1_point(eof1_point),
   .downstream_traffic_seen(downstream_traffic_seen), .oc_raw(oc_raw),
   .hub_cfg(hub_cfg), .eof1_eop_send(eof1_eop_send), .oc_qualified(oc_qualified));
`default_nettype wire

// [bench/hpc_host_model.sv]
// Host-side frame model: link speed, EOF1 markers, downstream traffic.
// Assumes the bench calls frame() from its main sequence.
`timescale 1ns/10ps
`default_nettype none
module hpc_host_model (
   input wire logic hclk,
   input wire logic eof1_eop_send,
   output logic full_speed,
   output logic eof1_point,
   output logic downstream_traffic_seen
);
   // EOP pulses seen from the hub
   int eop_count = 0;
   initial begin
      full_speed = 1'b0;
      eof1_point = 1'b0;
      downstream_traffic_seen = 1'b0;
   end
   // Every EOP pulse is one cycle wide, so count per edge
   always @(posedge hclk) begin
      if (eof1_eop_send === 1'b1) begin
         eop_count++;
      end
   end
   task automatic frame(input logic fs, input logic busy);
      @(posedge hclk);
      full_speed <= fs;
      downstream_traffic_seen <= busy;
      eof1_point <= 1'b1;
      @(posedge hclk);
      eof1_point <= 1'b0;
      repeat (3) @(posedge hclk);
   endtask
endmodule
`default_nettype wire

// [bench/tb_top.sv]
// Self-checking bench for the hub configuration bank over AHB-Lite.
// Assumes zero-wait slave, byte address four times the register index.
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import hpc_pkg::*;
;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [15:0] haddr = 16'h0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h00000000;
   logic hreadyout, hresp, eof1_eop_send, full_speed, eof1_point, traffic;
   logic [31:0] hrdata;
   logic cfg_from_strap = 1'b0;
   logic [1:0] fix_pins = 2'h0;
   logic [1:0] off_pins = 2'h0;
   logic [2:0] oc_raw = 3'h0;
   logic [2:0] oc_qualified;
   hpc_hub_cfg_t hub_cfg;
   int errors = 0;
   int checks = 0;
   int cycles = 0;
   int n;
   // Register table; last entry is an unmapped hole
   logic [15:0] idx_t [9] = '{IDX_CFG_ONE, IDX_CFG_TWO, IDX_CFG_THREE, IDX_FIXED_PORTS,
      IDX_OFF_SELF, IDX_OFF_BUS, IDX_REMAP_LOW, IDX_REMAP_THIRD, 16'h00E8};
   logic [7:0] msk_t [9] = '{MASK_CFG_ONE, MASK_CFG_TWO, MASK_CFG_THREE, MASK_PORTS,
      MASK_PORTS, MASK_PORTS, MASK_REMAP_LOW, MASK_REMAP_THIRD, 8'h00};
   int dly_t [4] = '{5, 10, 20, 40};
   always #5 hclk = ~hclk;
   hpc_hub_config u_hpc_hub_config (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .cfg_from_strap(cfg_from_strap), .fixed_device_strap_pins(fix_pins),
      .port_off_strap_pins(off_pins), .full_speed(full_speed), .eof1_point(eof1_point),
      .downstream_traffic_seen(traffic), .oc_raw(oc_raw), .hub_cfg(hub_cfg),
      .eof1_eop_send(eof1_eop_send), .oc_qualified(oc_qualified));
   hpc_host_model u_hpc_host_model (.hclk(hclk), .eof1_eop_send(eof1_eop_send),
      .full_speed(full_speed), .eof1_point(eof1_point), .downstream_traffic_seen(traffic));
   ////////////////////////////////////////////////////////////////////////
   // Verdict and end of run
   task automatic conclude;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Compare and report a mismatch at once
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One single AHB transfer; waits on hready in both phases
   task automatic ahb(input logic [15:0] idx, input logic wr, input logic [7:0] wd,
      output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {idx[13:0], 2'b00};
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h000000, wd};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hresp ? '1 : hrdata;
   endtask
   task automatic wr(input logic [15:0] idx, input logic [7:0] d);
      logic [31:0] x;
      ahb(idx, 1'b1, d, x);
   endtask
   task automatic rd_chk(input logic [15:0] idx, input logic [7:0] e);
      logic [31:0] x;
      ahb(idx, 1'b0, 8'h00, x);
      chk(x, {24'h000000, e});
   endtask
   // Decoded outputs follow one edge after a store or strap change
   task automatic look;
      repeat (2) @(posedge hclk);
   endtask
   // Hang guard; the whole run needs well under this
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 6000) begin
         errors++;
         conclude;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      // Reset values, then writable bits and an unmapped hole
      for (int i = 0; i < 9; i++) begin
         rd_chk(idx_t[i], 8'h00);
      end
      for (int i = 0; i < 9; i++) begin
         wr(idx_t[i], (i == 0) ? 8'h7F : 8'hFF); // sensing off only bus-powered
         rd_chk(idx_t[i], ((i == 0) ? 8'h7F : 8'hFF) & msk_t[i]);
      end
      look;
      chk(hub_cfg.fixed_ports, 3'b111);
      for (int i = 0; i < 9; i++) begin
         wr(idx_t[i], 8'h00);
      end
      // EOF1: quiet, busy, not full speed, suppressed
      for (int k = 0; k < 4; k++) begin
         wr(IDX_CFG_ONE, (k == 3) ? 8'h08 : 8'h00);
         look;
         n = u_hpc_host_model.eop_count;
         u_hpc_host_model.frame(k != 2, k == 1);
         chk(u_hpc_host_model.eop_count - n, (k == 0) ? 1 : 0);
      end
      // Per-port sensing with individual power, every delay code
      wr(IDX_CFG_ONE, 8'h03);
      look;
      chk({hub_cfg.power_individual, hub_cfg.sense_mode}, 3'b101);
      for (int c = 0; c < 4; c++) begin
         wr(IDX_CFG_TWO, {2'b00, c[1:0], 4'h0});
         look;
         @(posedge hclk);
         oc_raw <= 3'b001;
         n = 0;
         while (oc_qualified[0] !== 1'b1 && n < 60) begin
            @(posedge hclk);
            n++;
         end
         chk(n, dly_t[c] + 1);
         chk(oc_qualified, 3'b001);
         oc_raw <= 3'b000;
         look;
      end
      // Ganged sensing, then sensing off while bus-powered
      wr(IDX_CFG_TWO, 8'h00);
      for (int m = 0; m < 2; m++) begin
         wr(IDX_CFG_ONE, (m == 0) ? 8'h00 : 8'h04); // sensing off only bus-powered
         look;
         oc_raw <= 3'b100;
         repeat (8) @(posedge hclk);
         chk(oc_qualified, (m == 0) ? 3'b111 : 3'b000);
         oc_raw <= 3'b000;
         look;
      end
      // Compound and fixed ports from registers
      wr(IDX_CFG_TWO, 8'h08);
      wr(IDX_FIXED_PORTS, 8'h02); // reader port marked fixed
      look;
      chk({hub_cfg.compound, hub_cfg.fixed_ports}, 4'b1001);
      wr(IDX_CFG_TWO, 8'h00);
      look;
      chk({hub_cfg.compound, hub_cfg.fixed_ports}, 4'b0001);
      // Strap mode: pins decide fixed and disabled ports
      for (int s = 0; s < 2; s++) begin
         cfg_from_strap <= 1'b1;
         fix_pins <= (s == 0) ? 2'b10 : 2'b00;
         off_pins <= 2'b10;
         look;
         chk({hub_cfg.compound, hub_cfg.fixed_ports}, (s == 0) ? 4'b1010 : 4'b0000);
         chk({hub_cfg.port_count, hub_cfg.port_enabled}, 5'b10011);
      end
      cfg_from_strap <= 1'b0;
      // Standard numbering from the self and bus disable registers
      wr(IDX_CFG_ONE, 8'h80);
      wr(IDX_OFF_SELF, 8'h04);
      wr(IDX_OFF_BUS, 8'h08);
      look;
      chk({hub_cfg.port_count, hub_cfg.port_enabled, hub_cfg.reported_p1,
         hub_cfg.reported_p3}, 9'b10_101_01_10);
      wr(IDX_CFG_ONE, 8'h00);
      look;
      chk({hub_cfg.port_count, hub_cfg.port_enabled, hub_cfg.reported_p1,
         hub_cfg.reported_p2}, 9'b10_011_01_10);
      // Remap mode numbers from the two remap registers
      wr(IDX_CFG_THREE, 8'h08);
      wr(IDX_REMAP_LOW, 8'h12);
      wr(IDX_REMAP_THIRD, 8'h03);
      look;
      chk({hub_cfg.remap_mode, hub_cfg.reported_p1, hub_cfg.reported_p2,
         hub_cfg.reported_p3}, 7'b1_10_01_11);
      conclude;
   end
endmodule
`default_nettype wire
